/* File: logic/sense_ctrl_regs.vh */
// Register offsets, field positions, reset values and timing for the sense control block.
`ifndef SENSE_CTRL_REGS_VH
`define SENSE_CTRL_REGS_VH
// Byte offsets of the registers on the AXI4-Lite port.
`define GENERAL_CONFIG_OFS    8'h00
`define OVERCURRENT_CONFIG_OFS 8'h04
`define RETRY_CONFIG0_OFS     8'h08
`define RETRY_CONFIG1_OFS     8'h0c
`define SENSE_STATUS_OFS      8'h10
`define SENSE_VALUE_OFS       8'h14
// Field positions.
`define SEL_CH0_BIT           0
`define SEL_CH1_BIT           1
`define HOLD_SEL_BIT          2
`define LOW_RATIO_BIT         0
`define OFFSET_POL_BIT        8
// Reset values.
`define GENERAL_CONFIG_RST    32'h0000_0001
`define OVERCURRENT_CONFIG_RST 32'h0000_0000
`define RETRY_CONFIG_RST      32'h0000_0000
// Sense ratio divisors, 1/1500 and 1/500.
`define HIGH_RATIO_DIV        1500
`define LOW_RATIO_DIV         500
// Settling time after turn-on, in ns, and the clock period in ns.
`define SETTLE_NS             2000
`define CLK_NS                40
`define SETTLE_CYC            ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
// AXI responses.
`define RESP_OKAY             2'b00
`define RESP_SLVERR           2'b10
`endif

/* File: logic/pin_sync.v */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk_i,   // System clock.
  input  wire             nrst_i,  // Asynchronous reset, active low.
  input  wire             ce_i,    // Clock enable; state freezes while low.
  input  wire [WIDTH-1:0] pin_i,   // Raw asynchronous inputs.
  output reg  [WIDTH-1:0] sync_o   // Filtered, synchronised levels.
);
  reg [WIDTH-1:0] s1_r;  // First stage, read only by the second stage.
  reg [WIDTH-1:0] s2_r;  // Second stage.
  reg [WIDTH-1:0] s3_r;  // Third stage.

  // A bit follows the third stage only while stages two and three agree, so a one-cycle glitch is never seen.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r   <= {WIDTH{1'b0}};
      s2_r   <= {WIDTH{1'b0}};
      s3_r   <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      s1_r   <= pin_i;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      sync_o <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & sync_o);
    end
  end
endmodule // pin_sync
`default_nettype wire

/* File: logic/load_current_sense_control.v */
// Load-current sense control with AXI4-Lite registers for a dual high-side switch.
//
// What this block does
// - Hold select 0 synchronous, 1 track-and-hold.
// - Hold select bit resets to 0.
// - Strobe low once settled, until switch-off.
// - Synchronous mode: no current shown when off.
// - Track-and-hold: sample at off, present held.
// - Track-and-hold: strobe high at switch-off capture.
// - Channel change discards held sample, reacquires.
// - Ratio bit picks 1/1500 or 1/500.
// - Low ratio reduces overcurrent thresholds.
// - Offset polarity bit D8: 1 positive, 0 negative.
// - Held sample keeps polarity active at off.
// - Sense in range only below lower overcurrent threshold.
// - Overcurrent window disables sensing, strobe high.
// - Two select bits pick ch0, ch1 or temperature.
`include "sense_ctrl_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module load_current_sense_control #(
  parameter DW = 16  // Width of the digitised current and temperature words.
) (
  input  wire          clk_i,                 // 25 MHz clock.
  input  wire          nrst_i,                // Asynchronous reset, active low.
  input  wire          ce_i,                  // Clock enable.
  input  wire [7:0]    awaddr_i,              // Write address.
  input  wire          awvalid_i,             // Write address valid.
  output reg           awready_o,             // Write address ready.
  input  wire [31:0]   wdata_i,               // Write data.
  input  wire [3:0]    wstrb_i,               // Write byte strobes.
  input  wire          wvalid_i,              // Write data valid.
  output reg           wready_o,              // Write data ready.
  output reg  [1:0]    bresp_o,               // Write response.
  output reg           bvalid_o,              // Write response valid.
  input  wire          bready_i,              // Write response ready.
  input  wire [7:0]    araddr_i,              // Read address.
  input  wire          arvalid_i,             // Read address valid.
  output reg           arready_o,             // Read address ready.
  output reg  [31:0]   rdata_o,               // Read data.
  output reg  [1:0]    rresp_o,               // Read response.
  output reg           rvalid_o,              // Read data valid.
  input  wire          rready_i,              // Read data ready.
  input  wire [1:0]    ch_on_i,               // Channel on pins.
  input  wire [1:0]    oc_window_i,           // Overcurrent window active per channel.
  input  wire [1:0]    above_ocl_i,           // Load above lower overcurrent threshold.
  input  wire [DW-1:0] load_current0_i,       // Channel 0 load current word.
  input  wire [DW-1:0] load_current1_i,       // Channel 1 load current word.
  input  wire [DW-1:0] temperature_i,         // Device temperature word.
  output reg  [DW-1:0] sense_value_o,         // Value presented on the sense output.
  output reg           sense_valid_strobe_n_o, // Low while the sense value is valid.
  output reg           offset_positive_o,     // Offset sign in effect.
  output reg           low_ratio_o,           // High while the 1/500 ratio is selected.
  output reg           oc_reduced_o,          // High while reduced overcurrent thresholds apply.
  output reg           sense_in_range_o       // High while the load is within the sense range.
);
  // Sense state machine codes.
  localparam [1:0] ST_OFF    = 2'd0;  // Channel off or sensing idle.
  localparam [1:0] ST_SETTLE = 2'd1;  // Channel on, output settling.
  localparam [1:0] ST_VALID  = 2'd2;  // Output valid, strobe low.
  localparam [1:0] ST_HELD   = 2'd3;  // Track-and-hold sample presented.
  localparam integer SETTLE_LAST_I = `SETTLE_CYC - 1;  // Last count of the settling wait.
  localparam [15:0] SETTLE_LAST = SETTLE_LAST_I[15:0];  // Cut to the counter's width.
  localparam [2:0] IDX_GEN = 3'd0;  // Register indices from the address decoder.
  localparam [2:0] IDX_OCR = 3'd1;
  localparam [2:0] IDX_RT0 = 3'd2;
  localparam [2:0] IDX_RT1 = 3'd3;
  localparam [2:0] IDX_STA = 3'd4;
  localparam [2:0] IDX_VAL = 3'd5;
  localparam [2:0] IDX_BAD = 3'd7;

  reg  [31:0]   general_config_reg_r;     // Channel select and hold select.
  reg  [31:0]   overcurrent_config_reg_r; // Sense ratio select.
  reg  [31:0]   retry_config_reg0_r;      // Channel 0 offset polarity.
  reg  [31:0]   retry_config_reg1_r;      // Channel 1 offset polarity.
  reg  [7:0]    wr_addr_r;                // Captured write address.
  reg  [31:0]   wr_data_r;                // Captured write data.
  reg  [3:0]    wr_strb_r;                // Captured write strobes.
  reg  [1:0]    state_r;                  // Sense state.
  reg  [1:0]    state_nxt;                // Next sense state.
  reg  [15:0]   settle_cnt_r;             // Settling counter.
  reg  [DW-1:0] held_value_r;             // Track-and-hold sample.
  reg           held_pol_r;               // Offset polarity captured with the sample.
  reg  [1:0]    sel_prev_r;               // Channel select seen last cycle.
  wire [5:0]    pins_s;                   // Synchronised channel pins.
  wire [1:0]    sel;                      // Channel select field.
  wire          hold_mode;                // Track-and-hold selected.
  wire          low_ratio;                // Low-current ratio selected.
  wire          mon_ch;                   // Monitored channel index.
  wire          temp_sel;                 // Temperature selected instead of a current.
  wire          mon_on;                   // Monitored channel is on.
  wire          mon_ocw;                  // Overcurrent window on monitored channel.
  wire          mon_above;                // Monitored load above the sense range.
  wire          live_pol;                 // Live offset polarity of the monitored channel.
  wire [DW-1:0] mon_current;              // Load current of the monitored channel.
  wire [DW-1:0] live_value;               // Scaled live sense value.
  reg  [DW-1:0] value_nxt;                // Next presented value.

  // Channel state and overcurrent pins come from the power stage, so they are synchronised.
  pin_sync #(.WIDTH(6)) u_pin_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .pin_i  ({above_ocl_i, oc_window_i, ch_on_i}),
    .sync_o (pins_s)
  );

  // Maps a byte address to a register index; unmapped addresses give IDX_BAD.
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      if (addr == `GENERAL_CONFIG_OFS) begin
        reg_index = IDX_GEN;
      end else if (addr == `OVERCURRENT_CONFIG_OFS) begin
        reg_index = IDX_OCR;
      end else if (addr == `RETRY_CONFIG0_OFS) begin
        reg_index = IDX_RT0;
      end else if (addr == `RETRY_CONFIG1_OFS) begin
        reg_index = IDX_RT1;
      end else if (addr == `SENSE_STATUS_OFS) begin
        reg_index = IDX_STA;
      end else if (addr == `SENSE_VALUE_OFS) begin
        reg_index = IDX_VAL;
      end else begin
        reg_index = IDX_BAD;
      end
    end
  endfunction

  // Merges write data into an old word under the byte strobes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Register fields as the sense logic sees them.
  assign sel       = {general_config_reg_r[`SEL_CH1_BIT], general_config_reg_r[`SEL_CH0_BIT]};
  assign hold_mode = general_config_reg_r[`HOLD_SEL_BIT];
  assign low_ratio = overcurrent_config_reg_r[`LOW_RATIO_BIT];
  assign temp_sel  = (sel != 2'b01) && (sel != 2'b10);
  assign mon_ch    = (sel == 2'b10);
  assign mon_on    = pins_s[mon_ch];
  assign mon_ocw   = pins_s[2 + mon_ch];
  assign mon_above = pins_s[4 + mon_ch];
  assign live_pol  = mon_ch ? retry_config_reg1_r[`OFFSET_POL_BIT]
                            : retry_config_reg0_r[`OFFSET_POL_BIT];
  assign mon_current = mon_ch ? load_current1_i : load_current0_i;
  // Quotients are 32 bits wide, but a divided-down word always fits DW bits, so only those are kept.
  wire [31:0] quot_lo = {{(32-DW){1'b0}}, mon_current} / `LOW_RATIO_DIV;
  wire [31:0] quot_hi = {{(32-DW){1'b0}}, mon_current} / `HIGH_RATIO_DIV;
  assign live_value = low_ratio ? quot_lo[DW-1:0] : quot_hi[DW-1:0];

  // Next sense state; channel change, temperature select and the monitored channel's overcurrent window all restart sensing.
  always @* begin
    state_nxt = state_r;
    if (sel != sel_prev_r || temp_sel || mon_ocw) begin
      state_nxt = ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (mon_on) begin
            state_nxt = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (!mon_on) begin
            state_nxt = ST_OFF;
          end else if (settle_cnt_r == SETTLE_LAST) begin
            state_nxt = ST_VALID;
          end
        end
        ST_VALID: begin
          if (!mon_on) begin
            state_nxt = hold_mode ? ST_HELD : ST_OFF;
          end
        end
        default: begin
          if (mon_on) begin
            state_nxt = ST_SETTLE;
          end else if (!hold_mode) begin
            state_nxt = ST_OFF;
          end
        end
      endcase
    end
  end

  // Presented value per state: live while on, the held sample in hold, nothing in synchronous off.
  always @* begin
    value_nxt = {DW{1'b0}};
    if (temp_sel) begin
      value_nxt = temperature_i;
    end else if (state_nxt == ST_SETTLE || state_nxt == ST_VALID) begin
      value_nxt = live_value;
    end else if (state_nxt == ST_HELD) begin
      value_nxt = (state_r == ST_VALID) ? live_value : held_value_r;
    end
  end

  // Sense state, counters, track-and-hold sample and the sense outputs.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r                <= ST_OFF;
      settle_cnt_r           <= 16'h0000;
      held_value_r           <= {DW{1'b0}};
      held_pol_r             <= 1'b0;
      sel_prev_r             <= 2'b01;
      sense_value_o          <= {DW{1'b0}};
      sense_valid_strobe_n_o <= 1'b1;
      offset_positive_o      <= 1'b0;
      low_ratio_o            <= 1'b0;
      oc_reduced_o           <= 1'b0;
      sense_in_range_o       <= 1'b0;
    end else if (ce_i) begin
      state_r       <= state_nxt;
      sel_prev_r    <= sel;
      sense_value_o <= value_nxt;
      // The counter runs only while settling, so every turn-on waits the full time.
      if (state_nxt == ST_SETTLE && state_r == ST_SETTLE) begin
        settle_cnt_r <= settle_cnt_r + 16'h0001;
      end else begin
        settle_cnt_r <= 16'h0000;
      end
      // The sample and its polarity are taken together at switch-off, so later polarity writes do not move it.
      if (state_r == ST_VALID && state_nxt == ST_HELD) begin
        held_value_r <= live_value;
        held_pol_r   <= live_pol;
      end else if (state_nxt == ST_OFF) begin
        held_value_r <= {DW{1'b0}};
      end
      // Strobe is low only in the valid state.
      sense_valid_strobe_n_o <= (state_nxt != ST_VALID);
      offset_positive_o      <= (state_nxt == ST_HELD) ?
                                ((state_r == ST_VALID) ? live_pol : held_pol_r) : live_pol;
      low_ratio_o            <= low_ratio;
      oc_reduced_o           <= low_ratio;
      sense_in_range_o       <= (state_nxt == ST_VALID) && !mon_above;
    end
  end

  // AXI4-Lite write path: address and data are taken in either order, then written and answered.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      awready_o                <= 1'b1;
      wready_o                 <= 1'b1;
      bvalid_o                 <= 1'b0;
      bresp_o                  <= `RESP_OKAY;
      wr_addr_r                <= 8'h00;
      wr_data_r                <= 32'h0000_0000;
      wr_strb_r                <= 4'h0;
      general_config_reg_r     <= `GENERAL_CONFIG_RST;
      overcurrent_config_reg_r <= `OVERCURRENT_CONFIG_RST;
      retry_config_reg0_r      <= `RETRY_CONFIG_RST;
      retry_config_reg1_r      <= `RETRY_CONFIG_RST;
    end else if (ce_i) begin
      if (awvalid_i && awready_o) begin
        wr_addr_r <= awaddr_i;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        wr_data_r <= wdata_i;
        wr_strb_r <= wstrb_i;
        wready_o  <= 1'b0;
      end
      // Both halves held and no answer pending: perform the write once.
      if (!awready_o && !wready_o && !bvalid_o) begin
        bvalid_o <= 1'b1;
        bresp_o  <= `RESP_OKAY;
        case (reg_index(wr_addr_r))
          IDX_GEN: general_config_reg_r     <= merge(general_config_reg_r, wr_data_r, wr_strb_r);
          IDX_OCR: overcurrent_config_reg_r <= merge(overcurrent_config_reg_r, wr_data_r, wr_strb_r);
          IDX_RT0: retry_config_reg0_r      <= merge(retry_config_reg0_r, wr_data_r, wr_strb_r);
          IDX_RT1: retry_config_reg1_r      <= merge(retry_config_reg1_r, wr_data_r, wr_strb_r);
          IDX_STA, IDX_VAL: bresp_o         <= `RESP_OKAY;
          default: bresp_o                  <= `RESP_SLVERR;
        endcase
      end
      // The response handshake reopens both channels for the next write.
      if (bvalid_o && bready_i) begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path: the word is sampled at the address handshake and answered next cycle.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= `RESP_OKAY;
    end else if (ce_i) begin
      if (arvalid_i && arready_o) begin
        arready_o <= 1'b0;
        rvalid_o  <= 1'b1;
        rresp_o   <= `RESP_OKAY;
        rdata_o   <= 32'h0000_0000;
        case (reg_index(araddr_i))
          IDX_GEN: rdata_o <= general_config_reg_r;
          IDX_OCR: rdata_o <= overcurrent_config_reg_r;
          IDX_RT0: rdata_o <= retry_config_reg0_r;
          IDX_RT1: rdata_o <= retry_config_reg1_r;
          // Status shows the sense state, strobe, range flag and synchronised pins.
          IDX_STA: rdata_o <= {20'h00000, pins_s, sense_in_range_o,
                               sense_valid_strobe_n_o, offset_positive_o, 1'b0, state_r};
          IDX_VAL: rdata_o[DW-1:0] <= sense_value_o;
          default: rresp_o <= `RESP_SLVERR;
        endcase
      end
      if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end
endmodule // load_current_sense_control
`default_nettype wire

/* File: testbench/load_current_sense_control_checker.sv */
// Concurrent checks on the sense control ports.
`timescale 1ns/1ps
`default_nettype none
module load_current_sense_control_checker #(
  parameter DW = 16  // Width of the sense word.
) (
  input wire logic          clk_i,
  input wire logic          nrst_i,
  input wire logic          awvalid_i,
  input wire logic          awready_o,
  input wire logic          wvalid_i,
  input wire logic          wready_o,
  input wire logic          bvalid_o,
  input wire logic          arvalid_i,
  input wire logic          arready_o,
  input wire logic          rvalid_o,
  input wire logic [1:0]    ch_on_i,
  input wire logic [1:0]    oc_window_i,
  input wire logic [1:0]    above_ocl_i,
  input wire logic [DW-1:0] sense_value_o,
  input wire logic          sense_valid_strobe_n_o,
  input wire logic          low_ratio_o,
  input wire logic          oc_reduced_o,
  input wire logic          sense_in_range_o
);
  logic [15:0] on_cnt_r, off_cnt_r, quiet_cnt_r; // Run lengths of on, off and undisturbed cycles.
  logic [1:0]  ch_prev_r;                        // Channel pins one cycle back.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Pins pass a synchroniser, so the checks trust only runs well past its delay.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      on_cnt_r    <= '0;
      off_cnt_r   <= '0;
      quiet_cnt_r <= '0;
      ch_prev_r   <= 2'b00;
    end else begin
      on_cnt_r    <= (ch_on_i == 2'b00) ? '0 : on_cnt_r + 16'h1;
      off_cnt_r   <= (ch_on_i != 2'b00) ? '0 : off_cnt_r + 16'h1;
      quiet_cnt_r <= (awvalid_i || oc_window_i != 2'b00 || ch_on_i != ch_prev_r) ? '0 : quiet_cnt_r + 16'h1;
      ch_prev_r   <= ch_on_i;
    end
  end
  ratio_oc_a: assert property (oc_reduced_o == low_ratio_o)
    else $error("Threshold cut differs from ratio.");
  window_off_a: assert property ((oc_window_i == 2'b11) [*8] |-> sense_valid_strobe_n_o && sense_value_o == '0)
    else $error("Sensing active inside overcurrent window.");
  idle_strobe_a: assert property (off_cnt_r >= 16'd10 |-> sense_valid_strobe_n_o)
    else $error("Strobe low with both channels off.");
  settle_time_a: assert property ($fell(sense_valid_strobe_n_o) |-> on_cnt_r >= 16'd50)
    else $error("Strobe fell before settling.");
  valid_stays_a: assert property (!sense_valid_strobe_n_o && quiet_cnt_r >= 16'd8 |=> !sense_valid_strobe_n_o)
    else $error("Strobe rose without switch-off.");
  range_limit_a: assert property ((above_ocl_i == 2'b11) [*8] |-> !sense_in_range_o)
    else $error("In range above lower threshold.");
  write_answer_a: assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:3] bvalid_o)
    else $error("Write response missing.");
  read_answer_a: assert property (arvalid_i && arready_o |-> ##[1:2] rvalid_o)
    else $error("Read response missing.");
endmodule // load_current_sense_control_checker

bind load_current_sense_control load_current_sense_control_checker #(.DW(DW)) u_checker (
  .clk_i, .nrst_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o, .arvalid_i, .arready_o, .rvalid_o,
  .ch_on_i, .oc_window_i, .above_ocl_i, .sense_value_o, .sense_valid_strobe_n_o, .low_ratio_o, .oc_reduced_o,
  .sense_in_range_o);
`default_nettype wire

/* File: testbench/sense_reader_model.sv */
// Microcontroller model: reads the sense word and averages opposite-offset pairs.
`timescale 1ns/1ps
`default_nettype none
module sense_reader_model #(
  parameter int DW      = 16, // Width of the sense word.
  parameter int SPACING = 8   // Cycles of settling before a reading, standing for the filter delay.
) (
  input  wire logic          clk_i,      // System clock.
  input  wire logic          nrst_i,     // Reset, active low.
  input  wire logic          strobe_n_i, // Sense-valid strobe, low while valid.
  input  wire logic          pol_i,      // Offset polarity in effect.
  input  wire logic [DW-1:0] value_i,    // Converted sense value.
  output logic      [DW-1:0] avg_o,      // Offset-compensated average.
  output logic               pair_o      // Both polarities have been read.
);
  logic [DW-1:0] rd_r [2];  // Stored reading for each polarity.
  logic [1:0]    have_r;    // Which readings are stored.
  logic [7:0]    low_cnt_r; // Cycles the strobe has been low.
  // An early read would catch the filter still moving.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      have_r    <= 2'b00;
      low_cnt_r <= 8'h00;
    end else if (strobe_n_i) begin
      low_cnt_r <= 8'h00;
    end else begin
      low_cnt_r <= low_cnt_r + 8'h01;
      if (low_cnt_r == 8'(SPACING)) begin
        rd_r[pol_i]   <= value_i;
        have_r[pol_i] <= 1'b1;
      end
    end
  end
  // The mean of two opposite-offset readings cancels the random offset.
  assign avg_o  = DW'(({1'b0, rd_r[0]} + {1'b0, rd_r[1]}) >> 1);
  assign pair_o = &have_r;
endmodule // sense_reader_model
`default_nettype wire

/* File: testbench/load_current_sense_control_tb_top.sv */
// Self-checking bench for the sense control block.
`include "sense_ctrl_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module load_current_sense_control_tb_top;
  logic        clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1; // Clock, reset and enable.
  logic        awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0; // Write channel controls.
  logic        arvalid_i = 1'b0, rready_i = 1'b0; // Read channel controls.
  logic [7:0]  awaddr_i = 8'h00, araddr_i = 8'h00; // Register addresses.
  logic [31:0] wdata_i = 32'h0, seed = 32'd15386; // Write data and random state.
  logic [3:0]  wstrb_i = 4'hf; // All byte lanes written.
  logic [1:0]  ch_on_i = 2'b00, oc_window_i = 2'b00, above_ocl_i = 2'b00; // Channel pins.
  logic [15:0] load_current0_i = 16'h0, load_current1_i = 16'h0, temperature_i = 16'h0, cur0;
  wire         awready_o, wready_o, bvalid_o, arready_o, rvalid_o, pair;
  wire         sense_valid_strobe_n_o, offset_positive_o, low_ratio_o, oc_reduced_o, sense_in_range_o;
  wire  [1:0]  bresp_o, rresp_o;
  wire  [31:0] rdata_o;
  wire  [15:0] sense_value_o, avg;
  int          num_errors = 0, n_checks = 0;
  load_current_sense_control u_dut (
    .clk_i, .nrst_i, .ce_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o,
    .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .ch_on_i,
    .oc_window_i, .above_ocl_i, .load_current0_i, .load_current1_i, .temperature_i, .sense_value_o,
    .sense_valid_strobe_n_o, .offset_positive_o, .low_ratio_o, .oc_reduced_o, .sense_in_range_o);
  sense_reader_model u_mcu (.clk_i(clk_i), .nrst_i(nrst_i), .strobe_n_i(sense_valid_strobe_n_o),
    .pol_i(offset_positive_o), .value_i(sense_value_o), .avg_o(avg), .pair_o(pair));
  // Free-running 25 MHz clock.
  initial forever #20 clk_i = ~clk_i;
  // Repeatable xorshift source.
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // Expected sense word at the selected ratio.
  function automatic logic [15:0] scaled(input logic [15:0] c, input logic lo);
    return 16'(lo ? c / `LOW_RATIO_DIV : c / `HIGH_RATIO_DIV);
  endfunction
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // A wait that ran out is a mismatch and ends the run.
  task automatic tmo(input int n, input int lim);
    chk(32'(n >= lim), 32'h0);
    if (n >= lim) report_and_stop();
  endtask
  task automatic wait_strobe(input logic lvl, input int lim);
    int n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sense_valid_strobe_n_o !== lvl && n < lim);
    tmo(n, lim);
  endtask
  // One register access; each channel is released at the edge that takes it.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge clk_i);
    awaddr_i  <= a;
    araddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= wr;
    wvalid_i  <= wr;
    bready_i  <= wr;
    arvalid_i <= !wr;
    rready_i  <= !wr;
    do begin
      @(posedge clk_i);
      n++;
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (arready_o) arvalid_i <= 1'b0;
    end while (!(wr ? bvalid_o : rvalid_o) && n < 50);
    bready_i <= 1'b0;
    rready_i <= 1'b0;
    tmo(n, 50);
    chk(wr ? bresp_o : rresp_o, er);
    if (!wr) chk(rdata_o, d);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    axi(0, `GENERAL_CONFIG_OFS, 32'h1, `RESP_OKAY);
    axi(0, 8'h40, 32'h0, `RESP_SLVERR);
    for (int lo = 0; lo < 2; lo++) begin
      axi(1, `OVERCURRENT_CONFIG_OFS, 32'(lo), `RESP_OKAY);
      cur0 = rnd();
      load_current0_i <= cur0;
      ch_on_i <= 2'b01;
      wait_strobe(1'b0, 80);
      chk(sense_value_o, scaled(cur0, lo[0]));
      chk(oc_reduced_o, lo);
      ch_on_i <= 2'b00;
      wait_strobe(1'b1, 8);
      repeat (4) @(posedge clk_i);
      chk(sense_value_o, 32'h0);
      $display("Sync ratio %0d done", lo);
    end
    // Hold on channel 0; brisk switching, well above the slow limit.
    axi(1, `RETRY_CONFIG0_OFS, 32'h100, `RESP_OKAY);
    axi(1, `GENERAL_CONFIG_OFS, 32'h5, `RESP_OKAY);
    cur0 = rnd();
    load_current0_i <= cur0;
    ch_on_i <= 2'b01;
    wait_strobe(1'b0, 80);
    chk(offset_positive_o, 32'h1);
    repeat (12) @(posedge clk_i);
    ch_on_i <= 2'b00;
    wait_strobe(1'b1, 8);
    load_current0_i <= ~cur0;
    axi(1, `RETRY_CONFIG0_OFS, 32'h0, `RESP_OKAY);
    repeat (8) @(posedge clk_i);
    chk(sense_value_o, scaled(cur0, 1'b1));
    chk(offset_positive_o, 32'h1);
    ch_on_i <= 2'b01;
    wait_strobe(1'b0, 80);
    repeat (12) @(posedge clk_i);
    chk(offset_positive_o, 32'h0);
    chk(pair, 32'h1);
    chk(avg, (scaled(cur0, 1'b1) + scaled(~cur0, 1'b1)) / 2);
    $display("Hold and offset done");
    ch_on_i <= 2'b00;
    wait_strobe(1'b1, 8);
    axi(1, `GENERAL_CONFIG_OFS, 32'h6, `RESP_OKAY);
    repeat (8) @(posedge clk_i);
    chk(sense_value_o, 32'h0);
    load_current1_i <= ~cur0;
    ch_on_i <= 2'b10;
    wait_strobe(1'b0, 80);
    chk(sense_value_o, scaled(~cur0, 1'b1));
    oc_window_i <= 2'b11;
    repeat (10) @(posedge clk_i);
    chk(sense_valid_strobe_n_o, 32'h1);
    oc_window_i <= 2'b00;
    wait_strobe(1'b0, 80);
    above_ocl_i <= 2'b11;
    repeat (10) @(posedge clk_i);
    chk(sense_in_range_o, 32'h0);
    above_ocl_i <= 2'b00;
    repeat (10) @(posedge clk_i);
    chk(sense_in_range_o, 32'h1);
    $display("Channel, window, range done");
    ch_on_i <= 2'b00;
    for (int s = 0; s < 4; s += 3) begin
      axi(1, `GENERAL_CONFIG_OFS, 32'(s), `RESP_OKAY);
      temperature_i <= rnd();
      repeat (8) @(posedge clk_i);
      chk(sense_value_o, temperature_i);
    end
    axi(0, `GENERAL_CONFIG_OFS, 32'h3, `RESP_OKAY);
    $display("Temperature done");
    report_and_stop();
  end
endmodule // load_current_sense_control_tb_top
`default_nettype wire
